/* File: rtl/hbr_ctrl.sv */
// enable controller that drives the repeater enable pin from the a side
// Operation
// - enable high 100 ns before start
// - enable held 100 ns after stop
// - change enable only while bus idle
// - never join two repeater b sides
`timescale 1ns/10ps
`default_nettype none
module hbr_ctrl
  import hbr_pkg::*;
(
  // clock, reset, clock enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // local user request
  input wire logic en_req_i,
  // a-side bus pins, observed only; no b side is joined here
  input wire logic a_side_data_line_i,
  input wire logic a_side_clock_line_i,
  // repeater enable pin and status
  output logic repeater_en_o,
  output hbr_status_type status_o
);

  hbr_lines_type lines;
  hbr_lines_type lines_prev;
  hbr_state_type state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] since_stop;
  logic busy;
  logic start_det;
  logic stop_det;
  logic hold_ok;
  logic [CNT_W-1:0] en_age;
  logic [CNT_W-1:0] stop_age;

  // bus lines come from another domain, so they pass two flops first
  hbr_sync #(
    .W(2),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .d_i({a_side_data_line_i, a_side_clock_line_i}),
    .q_o({lines.data, lines.clock})
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lines_prev <= hbr_lines_type'(SYNC_RST);
    end else if (ce_i) begin
      lines_prev <= lines;
    end
  end

  // start: data falls with clock high; stop: data rises with clock high
  assign start_det = lines_prev.data && !lines.data && lines.clock && lines_prev.clock;
  assign stop_det = !lines_prev.data && lines.data && lines.clock && lines_prev.clock;

  // bus busy from start to stop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy <= BUSY_RST;
    end else if (ce_i) begin
      if (start_det) begin
        busy <= 1'b1;
      end else if (stop_det) begin
        busy <= 1'b0;
      end
    end
  end

  // cycles since the last stop, held at zero while busy, saturating at the hold figure
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      since_stop <= SINCE_STOP_RST;
    end else if (ce_i) begin
      if (stop_det || busy) begin
        since_stop <= CNT_RST;
      end else if (since_stop < HD_CYC) begin
        since_stop <= since_stop + 2'h1;
      end
    end
  end

  // a stop seen while idle must not drop the enable at once
  assign hold_ok = !busy && !start_det && !stop_det && (since_stop >= HD_CYC);

  // checker-side ages count ce cycles only, so a frozen clock
  // makes the timing checks stricter, never looser
  // cycles the enable has stood high
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      en_age <= CNT_RST;
    end else if (ce_i) begin
      if (!repeater_en_o) begin
        en_age <= CNT_RST;
      end else if (en_age < SU_CYC) begin
        en_age <= en_age + 2'h1;
      end
    end
  end

  // cycles since any stop, busy or not
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stop_age <= SINCE_STOP_RST;
    end else if (ce_i) begin
      if (stop_det) begin
        stop_age <= CNT_RST;
      end else if (stop_age < HD_CYC) begin
        stop_age <= stop_age + 2'h1;
      end
    end
  end

  // enable state machine; a request while the bus is busy waits, it is not lost
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_OFF;
      repeater_en_o <= EN_RST;
      cnt <= CNT_RST;
    end else if (ce_i) begin
      case (state)
        ST_OFF: begin
          if (en_req_i && !busy && !start_det) begin
            state <= ST_SETUP;
            repeater_en_o <= 1'b1;
            cnt <= CNT_RST;
          end
        end
        ST_SETUP: begin
          if (!en_req_i && hold_ok) begin
            state <= ST_OFF;
            repeater_en_o <= 1'b0;
          end else if (cnt == SU_CYC - 2'h1) begin
            state <= ST_ON;
          end else begin
            cnt <= cnt + 2'h1;
          end
        end
        ST_ON: begin
          if (!en_req_i && hold_ok) begin
            state <= ST_OFF;
            repeater_en_o <= 1'b0;
          end
        end
        default: begin
          state <= ST_OFF;
          repeater_en_o <= EN_RST;
        end
      endcase
    end
  end

  // local masters may issue a start only once ready is seen
  assign status_o.en = repeater_en_o;
  assign status_o.ready = (state == ST_ON);
  assign status_o.busy = busy;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_en_change_idle: assert property ($changed(repeater_en_o) |-> !$past(busy))
    else $error("enable changed while bus busy");
  a_ready_after_setup: assert property ($rose(status_o.ready) |->
    $past(repeater_en_o, 1) && $past(repeater_en_o, 2) && $past(repeater_en_o, 3))
    else $error("ready before setup time elapsed");
  a_fall_after_hold: assert property ($fell(repeater_en_o) |-> $past(since_stop) >= HD_CYC)
    else $error("enable dropped inside hold time");
  a_ready_needs_en: assert property (status_o.ready |-> repeater_en_o)
    else $error("ready while enable low");
  a_start_sets_busy: assert property (ce_i && start_det |=> busy)
    else $error("start not marked busy");
  a_stop_hold_low: assert property (ce_i && stop_det && repeater_en_o |=> repeater_en_o)
    else $error("enable dropped right at stop");
  // timing checks against the independent ages above, then request checks on each enable edge
  a_ready_en_age: assert property (status_o.ready |-> en_age == SU_CYC)
    else $error("ready with enable high too briefly");
  a_hold_stop_age: assert property ($fell(repeater_en_o) |->
    $past(stop_age) == HD_CYC && !$past(stop_det))
    else $error("enable dropped too soon after stop");
  a_drop_needs_req: assert property ($fell(repeater_en_o) |-> !$past(en_req_i))
    else $error("enable dropped while still requested");
  a_rise_needs_req: assert property ($rose(repeater_en_o) |-> $past(en_req_i))
    else $error("enable raised without request");
  // enable moves only on an idle bus; then busy tracking, ready hold and ce freeze checks
  a_no_rise_busy: assert property (ce_i && busy && !repeater_en_o |=> !repeater_en_o)
    else $error("enable raised during a transfer");
  a_rise_no_start: assert property ($rose(repeater_en_o) |-> !$past(start_det))
    else $error("enable raised on a start");
  a_drop_no_start: assert property ($fell(repeater_en_o) |-> !$past(start_det))
    else $error("enable dropped on a start");
  a_busy_needs_start: assert property ($rose(busy) |-> $past(start_det))
    else $error("busy without a start");
  a_stop_clears_busy: assert property (ce_i && stop_det && !start_det |=> !busy)
    else $error("stop left bus marked busy");
  a_ready_stays: assert property (ce_i && status_o.ready && en_req_i |=> status_o.ready)
    else $error("ready lost while still requested");
  a_freeze_ce: assert property (!ce_i |=> $stable(repeater_en_o) && $stable(busy))
    else $error("state moved with clock enable low");

  // main scenarios
  c_en_rise: cover property ($rose(repeater_en_o));
  c_ready: cover property ($rose(status_o.ready));
  c_start_on: cover property (status_o.ready && start_det);
  c_en_fall: cover property ($fell(repeater_en_o));
  c_wait_busy: cover property (en_req_i && busy && !repeater_en_o);

endmodule // hbr_ctrl
`default_nettype wire

/* File: rtl/hbr_pkg.sv */
// package: constants and carriers for the bus repeater enable controller
package hbr_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS = 40;
  localparam int SU_TIME_NS = 100;
  localparam int HD_TIME_NS = 100;
  // least times round up to whole cycles
  localparam int SU_CYC_INT = (SU_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HD_CYC_INT = (HD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] SU_CYC = CNT_W'(SU_CYC_INT);
  localparam logic [CNT_W-1:0] HD_CYC = CNT_W'(HD_CYC_INT);

  // values after reset
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
  localparam logic [CNT_W-1:0] SINCE_STOP_RST = HD_CYC;
  localparam logic EN_RST = 1'h0;
  localparam logic BUSY_RST = 1'h0;
  localparam logic [1:0] SYNC_RST = 2'h3;

  // controller states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_SETUP,
    ST_ON
  } hbr_state_type;

  // a-side bus lines as seen by this controller
  typedef struct packed {
    logic data;
    logic clock;
  } hbr_lines_type;

  // status shown to the local user
  typedef struct packed {
    logic en;
    logic ready;
    logic busy;
  } hbr_status_type;

endpackage

/* File: rtl/hbr_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module hbr_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and control
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // first stage is read only by the second
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else if (ce_i) begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule // hbr_sync
`default_nettype wire

/* File: dv/hbr_rep_model.sv */
// repeater device model joining a and b segments
`timescale 1ns/10ps
`default_nettype none
module hbr_rep_model (
  // enable pin and pull-downs, {data, clock}
  input wire logic en_i,
  input wire logic [1:0] a_low_i,
  input wire logic [1:0] b_low_i,
  // line levels, pulled up when released
  output logic [1:0] a_o,
  output logic [1:0] b_o
);
  logic on;
  assign on = (en_i !== 1'b0);
  // a side sees only outside b lows, never the buffered one
  assign a_o = ~(a_low_i | ({2{on}} & b_low_i));
  assign b_o = ~(b_low_i | ({2{on}} & a_low_i));
endmodule // hbr_rep_model
`default_nettype wire

/* File: dv/hbr_ctrl_tb_top.sv */
// bench for the repeater enable controller
`timescale 1ns/10ps
`default_nettype none
module hbr_ctrl_tb_top;
  import hbr_pkg::*;
  logic clk_i = 1'h0, srst_i = 1'h1, en_req_i = 1'h0, ce = 1'h1;
  logic [1:0] a_low = 2'h0, b_low = 2'h0, a_ln;
  logic repeater_en_o;
  hbr_status_type status_o;
  int miscompares = 0, checks_done = 0;
  wire logic [3:0] obs = {repeater_en_o, status_o};
  hbr_ctrl uut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .en_req_i(en_req_i),
    .a_side_data_line_i(a_ln[1]), .a_side_clock_line_i(a_ln[0]),
    .repeater_en_o(repeater_en_o), .status_o(status_o));
  hbr_rep_model dev (.en_i(repeater_en_o), .a_low_i(a_low), .b_low_i(b_low),
    .a_o(a_ln), .b_o());
  initial forever #20 clk_i = ~clk_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // read at the edge, so it shows the state after the previous edge
  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // half period of the 320 ns bus clock; v is {data, clock} level
  task automatic bus(input logic [1:0] v, input int on_a);
    if (on_a != 0) a_low <= ~v;
    else b_low <= ~v;
    tick(4);
  endtask
  task automatic t_enable;
    chk(obs, 4'h0);
    en_req_i <= 1'h1;
    tick(2);
    chk(obs, 4'hc);
    tick(2);
    chk(obs, 4'hc);
    tick(1);
    chk(obs, 4'he);
    en_req_i <= 1'h0;
    tick(2);
    chk(obs, 4'h0);
  endtask
  // request raised mid-frame must wait for the stop
  task automatic t_wait;
    bus(2'h1, 1);
    bus(2'h0, 1);
    en_req_i <= 1'h1;
    bus(2'h1, 1);
    chk(obs, 4'h1);
    bus(2'h3, 1);
    tick(10);
    chk(obs, 4'he);
  endtask
  // drop asked mid-frame on the far side; enable outlives the stop
  task automatic t_hold;
    bus(2'h1, 0);
    bus(2'h0, 0);
    en_req_i <= 1'h0;
    chk(obs, 4'hf);
    bus(2'h1, 0);
    bus(2'h3, 0);
    tick(2);
    chk(obs, 4'he);
    tick(4);
    chk(obs, 4'h0);
  endtask
  // clock enable low holds back a pending request
  task automatic t_freeze;
    ce <= 1'h0;
    en_req_i <= 1'h1;
    tick(4);
    chk(obs, 4'h0);
    ce <= 1'h1;
    tick(2);
    chk(obs, 4'hc);
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    tick(2);
    srst_i <= 0;
    t_enable;
    t_wait;
    t_hold;
    t_freeze;
    end_of_test;
  end
  // whole run is under 100 cycles
  initial begin
    #20000;
    miscompares++;
    end_of_test;
  end
endmodule // hbr_ctrl_tb_top
`default_nettype wire
